// ---- inc/ims_pkg.sv ----
package ims_pkg;

  // ------------------------------------------------------------
  // register map (word index on the plain register port)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 3;
  localparam logic [2:0]  REG_DATA_BUFFER = 3'h0;
  localparam logic [2:0]  REG_CONTROL     = 3'h1;
  localparam logic [2:0]  REG_SECOND_CTRL = 3'h2;
  localparam logic [2:0]  REG_ADDR_RELOAD = 3'h3;
  localparam logic [2:0]  REG_PORT_STATUS = 3'h4;
  localparam logic [2:0]  REG_EVENT_FLAGS = 3'h5;

  // control register fields
  localparam int unsigned CTL_WRITE_COLLISION_FLAG_BIT  = 7;
  localparam int unsigned CTL_OVFL_BIT  = 6;
  localparam int unsigned CTL_EN_BIT    = 5;
  localparam logic [3:0]  MODE_MASTER   = 4'h8;

  // second control register fields
  localparam int unsigned C2_START_BIT   = 0;
  localparam int unsigned C2_RESTART_BIT = 1;
  localparam int unsigned C2_STOP_BIT    = 2;
  localparam int unsigned C2_RECV_BIT    = 3;
  localparam int unsigned C2_ACKSEQ_BIT  = 4;
  localparam int unsigned C2_ACKVAL_BIT  = 5;
  localparam int unsigned C2_ACKRES_BIT  = 6;
  localparam int unsigned C2_GCALL_BIT   = 7;

  // port status and event flag fields
  localparam int unsigned ST_FULL_BIT  = 0;
  localparam int unsigned ST_START_BIT = 3;
  localparam int unsigned EV_IRQ_BIT   = 0;
  localparam int unsigned EV_COLL_BIT  = 1;

  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [6:0] RST_COUNT  = 7'h00;

  // ------------------------------------------------------------
  // timing: counter steps twice per instruction cycle
  // ------------------------------------------------------------
  localparam real         CLOCK_NS        = 5.0;
  localparam int unsigned INSTR_CLKS      = 4;
  localparam int unsigned STEPS_PER_INSTR = 2;
  localparam int unsigned STEP_CLKS       = INSTR_CLKS / STEPS_PER_INSTR;
  localparam logic [1:0]  STEP_LAST       = 2'(STEP_CLKS - 1);

  // bit positions within a byte frame
  localparam logic [3:0]  BIT_LAST_DATA = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } ims_lines_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START_WAIT, ST_START_HOLD,
    ST_RS_SCL_LOW, ST_RS_DATA, ST_RS_SCL_HIGH, ST_RS_BOTH_HIGH, ST_RS_SDA_LOW,
    ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH
  } ims_state_t;

endpackage : ims_pkg

// ---- logic/ims_seq.sv ----
module ims_seq (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  input  wire logic [ims_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [7:0]                 o_rdata,
  input  wire logic                       i_scl,
  output logic                            o_scl_o,
  output logic                            o_scl_oe,
  input  wire logic                       i_sda,
  output logic                            o_sda_o,
  output logic                            o_sda_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ims_pkg::ims_state_t state_ff, nxt_state;
  ims_pkg::ims_lines_t sync1_ff, sync2_ff, prev_ff, ln;
  logic [1:0] div_ff;
  logic [6:0] cnt_ff;
  logic       run_ff;
  logic [7:0] reload_ff, buffer_ff, shift_ff, rdata_ff;
  logic [3:0] bit_ff, mode_ff;
  logic       en_ff, write_collision_flag_ff, ovfl_ff, full_ff, sdet_ff, irq_ff, coll_ff;
  logic       sen_ff, restart_request_bit_ff, pen_ff, receive_request_bit_ff, ack_sequence_request_ff, ackval_ff, gcen_ff, ackres_ff;
  logic       scl_low_ff, sda_low_ff, nxt_scl_low, nxt_sda_low;
  logic       cnt_load, cnt_stop, ev_coll, ev_irq, ev_clr_sen, ev_clr_restart_request_bit;
  logic       ev_tx_done, ev_ack, ev_rx_done, sh_load, sh_tx, sh_rx, bit_clr, bit_inc;

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  wire wr_buf   = i_wr && (i_addr == ims_pkg::REG_DATA_BUFFER);
  wire wr_ctl   = i_wr && (i_addr == ims_pkg::REG_CONTROL);
  wire wr_c2    = i_wr && (i_addr == ims_pkg::REG_SECOND_CTRL);
  wire wr_rld   = i_wr && (i_addr == ims_pkg::REG_ADDR_RELOAD);
  wire wr_ev    = i_wr && (i_addr == ims_pkg::REG_EVENT_FLAGS);
  wire rd_buf   = i_rd && (i_addr == ims_pkg::REG_DATA_BUFFER);
  wire master   = en_ff && (mode_ff == ims_pkg::MODE_MASTER);
  wire idle     = (state_ff == ims_pkg::ST_IDLE);
  // start and restart lock the low command bits; events cannot queue
  wire in_start = (state_ff == ims_pkg::ST_START_WAIT) || (state_ff == ims_pkg::ST_START_HOLD);
  wire in_rs    = (state_ff >= ims_pkg::ST_RS_SCL_LOW) && (state_ff <= ims_pkg::ST_RS_SDA_LOW);
  wire c2_lock  = in_start || in_rs;

  // command acceptance, one at a time and only from idle
  wire go_start = master && idle && wr_c2 && i_wdata[ims_pkg::C2_START_BIT];
  wire go_rs    = master && idle && wr_c2 && !i_wdata[ims_pkg::C2_START_BIT]
                  && i_wdata[ims_pkg::C2_RESTART_BIT];
  wire go_rx    = master && idle && wr_c2 && !i_wdata[ims_pkg::C2_START_BIT]
                  && !i_wdata[ims_pkg::C2_RESTART_BIT] && i_wdata[ims_pkg::C2_RECV_BIT];
  wire go_tx    = master && idle && wr_buf;
  wire write_collision_flag_set = master && !idle && wr_buf;

  // ------------------------------------------------------------
  // step enable, synchroniser and counter expiry
  // ------------------------------------------------------------
  wire step     = (div_ff == ims_pkg::STEP_LAST);
  wire expire   = step && run_ff && (cnt_ff == ims_pkg::RST_COUNT);
  wire sda_fall = step && prev_ff.sda && !ln.sda && ln.scl;
  wire sda_rise = step && !prev_ff.sda && ln.sda && ln.scl;
  assign ln = sync2_ff;

  // two clocks per step: period of reload+1 steps gives fosc/(4*(n+1)) per bit
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= step ? 2'h0 : div_ff + 2'h1;
    end
  end

  // lines are resampled at the step rate only; first stage feeds second only
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= '{scl: 1'b1, sda: 1'b1};
      sync2_ff <= '{scl: 1'b1, sda: 1'b1};
      prev_ff  <= '{scl: 1'b1, sda: 1'b1};
    end else if (step) begin
      sync1_ff <= '{scl: i_scl, sda: i_sda};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // baud counter: load, count down, hold at zero until reloaded
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= ims_pkg::RST_COUNT;
      run_ff <= 1'b0;
    end else if (cnt_load) begin
      cnt_ff <= reload_ff[6:0];
      run_ff <= 1'b1;
    end else if (cnt_stop) begin
      run_ff <= 1'b0;
    end else if (step && run_ff && (cnt_ff != ims_pkg::RST_COUNT)) begin
      cnt_ff <= cnt_ff - 7'h01;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // the counter is stopped on entry to a clock-high state; it only starts
  // once the clock really reads high, so a stretching slave lengthens the bit
  always_comb begin
    nxt_state   = state_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    cnt_load    = 1'b0;
    cnt_stop    = 1'b0;
    ev_coll     = 1'b0;
    ev_irq      = 1'b0;
    ev_clr_sen  = 1'b0;
    ev_clr_restart_request_bit = 1'b0;
    ev_tx_done  = 1'b0;
    ev_ack      = 1'b0;
    ev_rx_done  = 1'b0;
    sh_load     = 1'b0;
    sh_tx       = 1'b0;
    sh_rx       = 1'b0;
    bit_clr     = 1'b0;
    bit_inc     = 1'b0;
    unique case (state_ff)
      ims_pkg::ST_IDLE: begin
        if (go_start) begin
          if (ln.scl && ln.sda) begin
            nxt_scl_low = 1'b0;
            nxt_sda_low = 1'b0;
            cnt_load    = 1'b1;
            nxt_state   = ims_pkg::ST_START_WAIT;
          end else begin
            ev_coll = 1'b1;
          end
        end else if (go_rs) begin
          nxt_scl_low = 1'b1;
          nxt_state   = ims_pkg::ST_RS_SCL_LOW;
        end else if (go_rx) begin
          nxt_scl_low = 1'b1;
          nxt_sda_low = 1'b0;
          cnt_load    = 1'b1;
          bit_clr     = 1'b1;
          nxt_state   = ims_pkg::ST_RX_LOW;
        end else if (go_tx) begin
          nxt_scl_low = 1'b1;
          nxt_sda_low = !i_wdata[7];
          cnt_load    = 1'b1;
          sh_load     = 1'b1;
          bit_clr     = 1'b1;
          nxt_state   = ims_pkg::ST_TX_LOW;
        end
      end
      ims_pkg::ST_START_WAIT: begin
        if (!ln.scl) begin
          ev_coll = 1'b1;
        end else if (expire) begin
          nxt_sda_low = 1'b1;
          cnt_load    = 1'b1;
          nxt_state   = ims_pkg::ST_START_HOLD;
        end
      end
      ims_pkg::ST_START_HOLD: begin
        if (expire) begin
          ev_clr_sen = 1'b1;
          ev_irq     = 1'b1;
          cnt_stop   = 1'b1;
          nxt_state  = ims_pkg::ST_IDLE;
        end
      end
      ims_pkg::ST_RS_SCL_LOW: begin
        nxt_sda_low = 1'b0;
        if (!ln.scl) begin
          cnt_load  = 1'b1;
          nxt_state = ims_pkg::ST_RS_DATA;
        end
      end
      ims_pkg::ST_RS_DATA: begin
        if (expire) begin
          if (ln.sda) begin
            nxt_scl_low = 1'b0;
            cnt_stop    = 1'b1;
            nxt_state   = ims_pkg::ST_RS_SCL_HIGH;
          end else begin
            ev_coll = 1'b1;
          end
        end
      end
      ims_pkg::ST_RS_SCL_HIGH: begin
        if (ln.scl) begin
          if (!ln.sda) begin
            ev_coll = 1'b1;
          end else begin
            cnt_load  = 1'b1;
            nxt_state = ims_pkg::ST_RS_BOTH_HIGH;
          end
        end
      end
      ims_pkg::ST_RS_BOTH_HIGH: begin
        if (!ln.scl) begin
          ev_coll = 1'b1;
        end else if (expire) begin
          nxt_sda_low = 1'b1;
          cnt_load    = 1'b1;
          nxt_state   = ims_pkg::ST_RS_SDA_LOW;
        end
      end
      ims_pkg::ST_RS_SDA_LOW: begin
        if (expire) begin
          ev_clr_restart_request_bit = 1'b1;
          ev_irq      = 1'b1;
          cnt_stop    = 1'b1;
          nxt_state   = ims_pkg::ST_IDLE;
        end
      end
      ims_pkg::ST_TX_LOW, ims_pkg::ST_RX_LOW: begin
        if (expire) begin
          nxt_scl_low = 1'b0;
          cnt_stop    = 1'b1;
          nxt_state   = (state_ff == ims_pkg::ST_TX_LOW) ? ims_pkg::ST_TX_HIGH
                                                          : ims_pkg::ST_RX_HIGH;
        end
      end
      ims_pkg::ST_TX_HIGH: begin
        if (!run_ff) begin
          cnt_load = ln.scl;
        end else if (expire) begin
          nxt_scl_low = 1'b1;
          bit_inc     = 1'b1;
          if (bit_ff == ims_pkg::BIT_ACK) begin
            ev_ack      = 1'b1;
            ev_irq      = 1'b1;
            cnt_stop    = 1'b1;
            nxt_sda_low = 1'b0;
            nxt_state   = ims_pkg::ST_IDLE;
          end else if (bit_ff == ims_pkg::BIT_LAST_DATA) begin
            ev_tx_done  = 1'b1;
            nxt_sda_low = 1'b0;
            cnt_load    = 1'b1;
            nxt_state   = ims_pkg::ST_TX_LOW;
          end else begin
            sh_tx       = 1'b1;
            nxt_sda_low = !shift_ff[6];
            cnt_load    = 1'b1;
            nxt_state   = ims_pkg::ST_TX_LOW;
          end
        end
      end
      ims_pkg::ST_RX_HIGH: begin
        if (!run_ff) begin
          cnt_load = ln.scl;
        end else if (expire) begin
          sh_rx       = 1'b1;
          nxt_scl_low = 1'b1;
          bit_inc     = 1'b1;
          if (bit_ff == ims_pkg::BIT_LAST_DATA) begin
            ev_rx_done = 1'b1;
            ev_irq     = 1'b1;
            cnt_stop   = 1'b1;
            nxt_state  = ims_pkg::ST_IDLE;
          end else begin
            cnt_load  = 1'b1;
            nxt_state = ims_pkg::ST_RX_LOW;
          end
        end
      end
    endcase
    // a collision releases both lines and drops back to idle
    if (ev_coll) begin
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      cnt_load    = 1'b0;
      cnt_stop    = 1'b1;
      nxt_state   = ims_pkg::ST_IDLE;
    end
  end

  // state, line drives, bit count and shifter
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_ff   <= ims_pkg::ST_IDLE;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      bit_ff     <= 4'h0;
      shift_ff   <= ims_pkg::RST_BYTE;
    end else begin
      state_ff   <= nxt_state;
      scl_low_ff <= nxt_scl_low;
      sda_low_ff <= nxt_sda_low;
      bit_ff     <= bit_clr ? 4'h0 : (bit_inc ? bit_ff + 4'h1 : bit_ff);
      if (sh_load) shift_ff <= i_wdata;
      else if (sh_tx) shift_ff <= {shift_ff[6:0], 1'b0};
      else if (sh_rx) shift_ff <= {shift_ff[6:0], ln.sda};
    end
  end

  // ------------------------------------------------------------
  // software registers; a hardware set always beats a software clear
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_ff     <= 1'b0;
      mode_ff   <= 4'h0;
      reload_ff <= ims_pkg::RST_BYTE;
      buffer_ff <= ims_pkg::RST_BYTE;
      write_collision_flag_ff   <= 1'b0;
      ovfl_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      coll_ff   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        en_ff   <= i_wdata[ims_pkg::CTL_EN_BIT];
        mode_ff <= i_wdata[3:0];
      end
      if (wr_rld) reload_ff <= i_wdata;
      if (go_tx) buffer_ff <= i_wdata;
      else if (ev_rx_done) buffer_ff <= {shift_ff[6:0], ln.sda};
      write_collision_flag_ff <= write_collision_flag_set || (wr_ctl ? i_wdata[ims_pkg::CTL_WRITE_COLLISION_FLAG_BIT] : write_collision_flag_ff);
      ovfl_ff <= (ev_rx_done && full_ff)
                 || (wr_ctl ? i_wdata[ims_pkg::CTL_OVFL_BIT] : ovfl_ff);
      irq_ff  <= ev_irq || (wr_ev ? i_wdata[ims_pkg::EV_IRQ_BIT] : irq_ff);
      coll_ff <= ev_coll || (wr_ev ? i_wdata[ims_pkg::EV_COLL_BIT] : coll_ff);
    end
  end

  // second control register, buffer full and bus start flag
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      {sen_ff, restart_request_bit_ff, pen_ff, receive_request_bit_ff, ack_sequence_request_ff} <= 5'h00;
      {ackval_ff, gcen_ff, ackres_ff, full_ff, sdet_ff} <= 5'h00;
    end else begin
      // a start refused for low lines must not leave the request bit standing
      sen_ff  <= (go_start && !ev_coll) || (sen_ff && !ev_clr_sen && !ev_coll);
      restart_request_bit_ff <= go_rs || (restart_request_bit_ff && !ev_clr_restart_request_bit && !ev_coll);
      receive_request_bit_ff <= go_rx || (receive_request_bit_ff && !ev_rx_done);
      if (wr_c2 && !c2_lock) begin
        pen_ff   <= i_wdata[ims_pkg::C2_STOP_BIT];
        ack_sequence_request_ff <= i_wdata[ims_pkg::C2_ACKSEQ_BIT];
      end
      if (wr_c2) begin
        ackval_ff <= i_wdata[ims_pkg::C2_ACKVAL_BIT];
        gcen_ff   <= i_wdata[ims_pkg::C2_GCALL_BIT];
      end
      if (ev_ack) ackres_ff <= ln.sda;
      full_ff <= go_tx || ev_rx_done || (full_ff && !ev_tx_done && !rd_buf);
      sdet_ff <= en_ff && (sda_fall || (sdet_ff && !sda_rise));
    end
  end

  // ------------------------------------------------------------
  // read path: data stands one cycle after the read strobe
  // ------------------------------------------------------------
  wire [7:0] ctl_rd = {write_collision_flag_ff, ovfl_ff, en_ff, 1'b0, mode_ff};
  wire [7:0] c2_rd  = {gcen_ff, ackres_ff, ackval_ff, ack_sequence_request_ff,
                       receive_request_bit_ff, pen_ff, restart_request_bit_ff, sen_ff};
  wire [7:0] st_rd  = {4'h0, sdet_ff, 2'h0, full_ff};
  wire [7:0] ev_rd  = {6'h00, coll_ff, irq_ff};
  wire [7:0] rd_mux = (i_addr == ims_pkg::REG_DATA_BUFFER) ? buffer_ff :
                      (i_addr == ims_pkg::REG_CONTROL)     ? ctl_rd    :
                      (i_addr == ims_pkg::REG_SECOND_CTRL) ? c2_rd     :
                      (i_addr == ims_pkg::REG_ADDR_RELOAD) ? reload_ff :
                      (i_addr == ims_pkg::REG_PORT_STATUS) ? st_rd     :
                      (i_addr == ims_pkg::REG_EVENT_FLAGS) ? ev_rd     : 8'h00;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= ims_pkg::RST_BYTE;
    end else begin
      rdata_ff <= i_rd ? rd_mux : 8'h00;
    end
  end

  // open-drain pins: only ever pull low
  assign o_rdata  = rdata_ff;
  assign o_scl_o  = 1'b0;
  assign o_sda_o  = 1'b0;
  assign o_scl_oe = scl_low_ff;
  assign o_sda_oe = sda_low_ff;

endmodule : ims_seq

// ---- dv/ims_seq_properties.sv ----
// ------------------------------------------------------------
// sequencer port checks
// ------------------------------------------------------------
module ims_seq_properties (
  input wire logic                       i_clock,
  input wire logic                       i_rst,
  input wire logic [ims_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0]                 i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [7:0]                 o_rdata,
  input wire logic                       o_scl_o,
  input wire logic                       o_scl_oe,
  input wire logic                       o_sda_o,
  input wire logic                       o_sda_oe
);
  logic [6:0] rl_ff;
  logic [7:0] byte_ff;
  logic [3:0] pc_ff;
  logic       tx_ff;
  logic [8:0] ph_ff;
  // a buffer write during a byte out, before its ninth clock release, must not retarget the bit checks
  wire acc = i_wr && i_addr == ims_pkg::REG_DATA_BUFFER && !(tx_ff && pc_ff < 4'h9);
  wire c2w = i_wr && i_addr == ims_pkg::REG_SECOND_CTRL;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // reload value, byte in flight, clock releases and phase length
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rl_ff   <= 7'h00;
      byte_ff <= 8'h00;
      pc_ff   <= 4'h0;
      tx_ff   <= 1'b0;
      ph_ff   <= 9'h000;
    end else begin
      if (i_wr && i_addr == ims_pkg::REG_ADDR_RELOAD) rl_ff <= i_wdata[6:0];
      if (acc) byte_ff <= i_wdata;
      if (acc || c2w) pc_ff <= 4'h0;
      else if ($fell(o_scl_oe) && pc_ff != 4'hF) pc_ff <= pc_ff + 4'h1;
      if (acc || c2w) tx_ff <= acc;
      ph_ff <= $changed(o_scl_oe) ? 9'h000 : ph_ff + 9'(ph_ff != 9'h1FF);
    end
  end
  pins_low_a: assert property (!o_scl_o && !o_sda_o)
    else $error("pin data outputs not low");
  read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  sda_release_a: assert property ($fell(o_sda_oe) |-> o_scl_oe)
    else $error("data released while clock high");
  msb_first_a: assert property ($fell(o_scl_oe) && tx_ff && pc_ff < 4'h8
    |-> o_sda_oe == !byte_ff[3'(4'h7 - pc_ff)]) else $error("wrong data bit at clock release");
  ack_free_a: assert property ($fell(o_scl_oe) && tx_ff && pc_ff == 4'h8 |-> !o_sda_oe)
    else $error("data not released for acknowledge");
  nine_pulses_a: assert property (tx_ff |-> pc_ff <= 4'h9)
    else $error("more than nine clock pulses per byte");
  hold_low_a: assert property ($rose(o_scl_oe) && tx_ff && pc_ff == 4'h9
    |=> (o_scl_oe && !o_sda_oe) [*8]) else $error("clock not held low after byte");
  phase_len_a: assert property ($changed(o_scl_oe) |-> ph_ff >= {1'b0, rl_ff, 1'b0})
    else $error("clock phase shorter than one period");
endmodule : ims_seq_properties

bind ims_seq ims_seq_properties u_ims_seq_properties (.i_clock, .i_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_scl_o, .o_scl_oe, .o_sda_o, .o_sda_oe);

// ---- dv/ims_slave_model.sv ----
// ------------------------------------------------------------
// addressed slave on the two-wire bus
// ------------------------------------------------------------
module ims_slave_model (
  input  wire logic       i_clock,
  input  wire logic       i_scl,
  input  wire logic       i_arm,
  input  wire logic       i_rx,
  input  wire logic       i_ack,
  input  wire logic       i_slow,
  input  wire logic       i_jam,
  input  wire logic [7:0] i_byte,
  output logic            o_scl_oe,
  output logic            o_sda_oe
);
  logic       scl_q;
  logic       drv_ff;
  logic [3:0] r_ff;
  logic [3:0] hold_ff;
  logic [3:0] st_ff;
  wire        fall = scl_q && !i_scl;
  assign o_scl_oe = i_jam || st_ff != 4'h0;
  assign o_sda_oe = i_jam || drv_ff;
  // data changes only on arming or after a falling clock; ack is held past the ninth fall
  always_ff @(posedge i_clock) begin
    scl_q <= i_scl;
    if (i_arm) begin
      r_ff    <= 4'h0;
      hold_ff <= 4'h0;
      st_ff   <= 4'h0;
      drv_ff  <= i_rx && !i_byte[7];
    end else begin
      if (!scl_q && i_scl) r_ff <= r_ff + 4'h1;
      if (st_ff != 4'h0) st_ff <= st_ff - 4'h1;
      else if (fall && i_slow) st_ff <= 4'hC;
      if (hold_ff != 4'h0) hold_ff <= hold_ff - 4'h1;
      if (hold_ff == 4'h1) drv_ff <= 1'b0;
      if (fall && r_ff == 4'h9) hold_ff <= 4'h8;
      else if (fall) drv_ff <= i_rx ? r_ff < 4'h8 && !i_byte[3'(4'h7 - r_ff)]
                                    : r_ff == 4'h8 && i_ack;
    end
  end
endmodule : ims_slave_model

// ---- dv/testbench.sv ----
// ------------------------------------------------------------
// sequencer bench
// ------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rst, wr, rd, arm, rx, ack, slow, jam, scl_oe, sda_oe, s_scl, s_sda;
  logic [2:0] addr;
  logic [7:0] wdata, rbyte, rdata, got;
  int         n_mismatch, comparisons;
  wire        scl_w = !(scl_oe || s_scl);
  wire        sda_w = !(sda_oe || s_sda);
  always #2.5 clock = !clock;
  ims_seq u_ims_seq (.i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_scl(scl_w), .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda_w),
    .o_sda_o(), .o_sda_oe(sda_oe));
  ims_slave_model u_ims_slave_model (.i_clock(clock), .i_scl(scl_w), .i_arm(arm), .i_rx(rx),
    .i_ack(ack), .i_slow(slow), .i_jam(jam), .i_byte(rbyte), .o_scl_oe(s_scl), .o_sda_oe(s_sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wreg
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rreg
  task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
    rreg(a, got);
    for (int k = 0; k < 300 && got[b] !== v; k++) rreg(a, got);
    check(8'(got[b]), 8'(v));
  endtask : wait_bit
  task automatic arm_model(input logic m, input logic a, input logic s, input logic [7:0] b);
    rx <= m;
    ack <= a;
    slow <= s;
    rbyte <= b;
    arm <= 1'b1;
    @(posedge clock);
    arm <= 1'b0;
    wreg(ims_pkg::REG_EVENT_FLAGS, 8'h00);
  endtask : arm_model
  task automatic t_collide;
    jam <= 1'b1;
    repeat (12) @(posedge clock);
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h01);
    repeat (12) @(posedge clock);
    rreg(ims_pkg::REG_EVENT_FLAGS, got);
    check(got & 8'h02, 8'h02);
    rreg(ims_pkg::REG_SECOND_CTRL, got);
    check(got & 8'h01, 8'h00);
    check(8'(sda_oe), 8'h00);
    jam <= 1'b0;
    repeat (12) @(posedge clock);
  endtask : t_collide
  task automatic t_start;
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h01);
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h18);
    wait_bit(ims_pkg::REG_SECOND_CTRL, 0, 1'b0);
    check({6'h00, sda_oe, scl_oe}, 8'h02);
    rreg(ims_pkg::REG_PORT_STATUS, got);
    check(got & 8'h08, 8'h08);
    rreg(ims_pkg::REG_SECOND_CTRL, got);
    check(got & 8'h18, 8'h00);
  endtask : t_start
  task automatic t_tx(input logic [7:0] b, input logic a, input logic s);
    arm_model(1'b0, a, s, 8'h00);
    wreg(ims_pkg::REG_DATA_BUFFER, b);
    wreg(ims_pkg::REG_DATA_BUFFER, ~b);
    rreg(ims_pkg::REG_PORT_STATUS, got);
    check(got & 8'h01, 8'h01);
    wait_bit(ims_pkg::REG_EVENT_FLAGS, 0, 1'b1);
    rreg(ims_pkg::REG_SECOND_CTRL, got);
    check(got & 8'h40, a ? 8'h00 : 8'h40);
    rreg(ims_pkg::REG_PORT_STATUS, got);
    check(got & 8'h01, 8'h00);
    rreg(ims_pkg::REG_CONTROL, got);
    check(got & 8'h80, 8'h80);
    rreg(ims_pkg::REG_DATA_BUFFER, got);
    check(got, b);
    check(8'(scl_oe), 8'h01);
    wreg(ims_pkg::REG_CONTROL, 8'h28);
  endtask : t_tx
  task automatic t_restart;
    arm_model(1'b0, 1'b1, 1'b0, 8'h00);
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h02);
    wait_bit(ims_pkg::REG_SECOND_CTRL, 1, 1'b0);
    check({6'h00, sda_oe, scl_oe}, 8'h02);
    rreg(ims_pkg::REG_EVENT_FLAGS, got);
    check(got & 8'h01, 8'h01);
  endtask : t_restart
  task automatic t_rx(input logic [7:0] b);
    arm_model(1'b1, 1'b0, 1'b0, b);
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h08);
    wait_bit(ims_pkg::REG_EVENT_FLAGS, 0, 1'b1);
    rreg(ims_pkg::REG_SECOND_CTRL, got);
    check(got & 8'h08, 8'h00);
    rreg(ims_pkg::REG_PORT_STATUS, got);
    check(got & 8'h01, 8'h01);
  endtask : t_rx
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // main sequence: collision, start, bytes out with ack and nack, restart, bytes in
  initial begin
    {clock, wr, rd, rx, slow, jam, addr, wdata, rbyte} = '0;
    {rst, arm, ack} = 3'h7;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    arm <= 1'b0;
    wreg(ims_pkg::REG_CONTROL, 8'h28);
    wreg(ims_pkg::REG_ADDR_RELOAD, 8'h83);
    t_collide;
    t_start;
    t_tx(8'hA5, 1'b1, 1'b0);
    t_tx(8'h3C, 1'b0, 1'b1);
    t_restart;
    t_tx(8'hC3, 1'b1, 1'b0);
    t_rx(8'h96);
    rreg(ims_pkg::REG_DATA_BUFFER, got);
    check(got, 8'h96);
    rreg(ims_pkg::REG_PORT_STATUS, got);
    check(got & 8'h01, 8'h00);
    wreg(ims_pkg::REG_SECOND_CTRL, 8'h10);
    rreg(ims_pkg::REG_SECOND_CTRL, got);
    check(got & 8'h10, 8'h10);
    t_rx(8'h5A);
    t_rx(8'h21);
    rreg(ims_pkg::REG_CONTROL, got);
    check(got & 8'h40, 8'h40);
    conclude;
  end
  // watchdog well beyond the expected run length
  initial begin
    #100us;
    n_mismatch++;
    conclude;
  end
endmodule : testbench
